// >>> core/ddrcb_pkg.sv
// Shared constants, command codes and state types for the DDR2 command issuer.
// Function
// - Pin levels are set up before the rising edge.
// - Self refresh entry/exit by CKE with refresh/deselect.
// - Burst of four is never cut short.
// - Power-down length bounded by refresh interval.
// - Power-down enter/exit by CKE with deselect/deselect.
// - Idle bank accepts activate, refresh, mode load.
// - Active bank accepts read, write, precharge.
// - Reading bank accepts read, write, precharge.
// - Writing bank accepts read, write, precharge.
// - Bank rules apply after self refresh exit delay.
// - Only NOP to a bank in transition.
// - Only NOP during refresh, mode, precharge-all recovery.
// - Unlisted command/state pairs are never issued; the code issues precharge-all to idle banks and power-down in any state.
package ddrcb_pkg;
    localparam int CLK_MHZ     = 50;
    // Times in ns as a plain default; real values come with the part grade.
    localparam int T_RCD_NS    = 15;
    localparam int T_RP_NS     = 15;
    localparam int T_RFC_NS    = 105;
    localparam int T_XSNR_NS   = 115;
    localparam int T_PD_MAX_NS = 7800;
    localparam int T_MRD_CYC   = 2;
    localparam int T_XP_CYC    = 2;
    localparam int BURST_LEN   = 4;
    localparam int BURST_CYC   = BURST_LEN / 2;
    localparam int TMR_W       = 8;

    // Least times round up to whole cycles, never below one.
    function automatic int cyc_up(input int ns);
        int c;
        c = (ns * CLK_MHZ + 999) / 1000;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int C_RCD    = cyc_up(T_RCD_NS);
    localparam int C_RP     = cyc_up(T_RP_NS);
    localparam int C_RFC    = cyc_up(T_RFC_NS);
    localparam int C_XSNR   = cyc_up(T_XSNR_NS);
    // Longest time rounds down.
    localparam int C_PD_MAX = (T_PD_MAX_NS * CLK_MHZ) / 1000;

    localparam int A_AP_BIT  = 10;
    // Pin patterns in the order cs_n, ras_n, cas_n, we_n.
    localparam logic [3:0] PIN_MRS  = 4'h0;
    localparam logic [3:0] PIN_REF  = 4'h1;
    localparam logic [3:0] PIN_PRE  = 4'h2;
    localparam logic [3:0] PIN_ACT  = 4'h3;
    localparam logic [3:0] PIN_WR   = 4'h4;
    localparam logic [3:0] PIN_RD   = 4'h5;
    localparam logic [3:0] PIN_NOP  = 4'h7;
    localparam logic [3:0] PIN_DSEL = 4'hf;

    typedef enum logic [3:0] {
        DDRCB_NOP  = 4'h0, DDRCB_ACT  = 4'h1, DDRCB_RD   = 4'h2, DDRCB_WR   = 4'h3,
        DDRCB_PRE  = 4'h4, DDRCB_PREA = 4'h5, DDRCB_REF  = 4'h6, DDRCB_MRS  = 4'h7,
        DDRCB_SRE  = 4'h8, DDRCB_SRX  = 4'h9, DDRCB_PDE  = 4'ha, DDRCB_PDX  = 4'hb
    } ddrcb_cmd_t;

    typedef enum logic [2:0] {
        BK_IDLE = 3'h0, BK_OPENING = 3'h1, BK_ACTIVE = 3'h3,
        BK_READ = 3'h2, BK_WRITE = 3'h6, BK_CLOSING = 3'h4
    } ddrcb_bank_st_t;

    typedef enum logic [2:0] {
        MN_RUN = 3'h0, MN_WAIT = 3'h1, MN_PD = 3'h3, MN_SR = 3'h2, MN_EXIT = 3'h6
    } ddrcb_main_st_t;
endpackage

// >>> core/ddrcb_bank.sv
// Per-bank state tracker driven by the commands the issuer puts on the pins.
module ddrcb_bank
    import ddrcb_pkg::*;
(
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_rst,
    input  wire logic                 i_hit,
    input  ddrcb_pkg::ddrcb_cmd_t     i_cmd,
    input  wire logic                 i_ap,
    output ddrcb_pkg::ddrcb_bank_st_t o_state,
    output logic                      o_busy
);
    typedef struct packed {
        ddrcb_bank_st_t    st;
        logic [TMR_W-1:0]  tmr;
    } ddrcb_bk_t;

    ddrcb_bk_t bk_ff;
    ddrcb_bk_t nxt_bk;

    // Timed states count down and then settle; a command moves any state, timed or stable.
    always_comb begin
        nxt_bk = bk_ff;
        if (bk_ff.tmr != '0) begin
            nxt_bk.tmr = bk_ff.tmr - 1'b1;
        end else if (bk_ff.st == BK_OPENING || bk_ff.st == BK_READ || bk_ff.st == BK_WRITE) begin
            nxt_bk.st = BK_ACTIVE;
        end else if (bk_ff.st == BK_CLOSING) begin
            nxt_bk.st = BK_IDLE;
        end
        if (i_hit) begin
            case (i_cmd)
                DDRCB_ACT: begin
                    nxt_bk.st  = BK_OPENING;
                    nxt_bk.tmr = TMR_W'(C_RCD - 1);
                end
                DDRCB_RD, DDRCB_WR: begin
                    nxt_bk.st  = i_ap ? BK_CLOSING : ((i_cmd == DDRCB_RD) ? BK_READ : BK_WRITE);
                    nxt_bk.tmr = i_ap ? TMR_W'(BURST_CYC + C_RP - 1) : TMR_W'(BURST_CYC - 1);
                end
                DDRCB_PRE, DDRCB_PREA: begin
                    nxt_bk.st  = BK_CLOSING;
                    nxt_bk.tmr = TMR_W'(C_RP - 1);
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            bk_ff <= '{st: BK_IDLE, tmr: '0};
        end else begin
            bk_ff <= nxt_bk;
        end
    end

    assign o_state = bk_ff.st;
    // Opening and closing banks may only see NOP, so the issuer stalls on them.
    assign o_busy  = (bk_ff.st == BK_OPENING) || (bk_ff.st == BK_CLOSING);
endmodule

// >>> core/ddrcb_host.sv
// DDR2 command issuer: turns user requests into legal pin commands per bank state.
module ddrcb_host
    import ddrcb_pkg::*;
#(
    parameter int BANK_BITS = 2,
    parameter int ADDR_W    = 14,
    parameter int COL_BITS  = 10,
    parameter int PD_MAX    = C_PD_MAX,
    parameter int XSNR_CYC  = C_XSNR
) (
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_rst,
    input  wire logic                 i_req_valid,
    input  ddrcb_pkg::ddrcb_cmd_t     i_req_cmd,
    input  wire logic [2:0]           i_req_bank,
    input  wire logic [ADDR_W-1:0]    i_req_addr,
    input  wire logic                 i_req_ap,
    input  wire logic                 i_odt_req,
    output logic                      o_req_ready,
    output logic                      o_req_err,
    output logic                      o_cke,
    output logic                      o_cs_n,
    output logic                      o_ras_n,
    output logic                      o_cas_n,
    output logic                      o_we_n,
    output logic [2:0]                o_ba,
    output logic [ADDR_W-1:0]         o_addr,
    output logic                      o_odt
);
    import ddrcb_pkg::*;

    localparam int NBANK = 1 << BANK_BITS;
    localparam int CNT_W = 12;

    typedef struct packed {
        ddrcb_main_st_t    st;
        logic [CNT_W-1:0]  wait_cnt;
        logic [CNT_W-1:0]  pd_cnt;
        logic [1:0]        bst_cnt;
        logic              cke;
        logic [3:0]        pins;
        logic [2:0]        ba;
        logic [ADDR_W-1:0] addr;
        logic              odt;
        logic              err;
    } ddrcb_host_t;

    ddrcb_host_t     s_ff;
    ddrcb_host_t     nxt_s;
    ddrcb_bank_st_t  bank_st [NBANK];
    logic [NBANK-1:0] bank_busy;
    logic [NBANK-1:0] bank_idle;
    logic [NBANK-1:0] bank_hit;
    logic            issue;
    ddrcb_cmd_t      iss_cmd;
    logic [2:0]      iss_ba;
    logic            iss_ap;
    logic [BANK_BITS-1:0] tgt;
    logic            legal;
    logic            bank_cmd;

    // Upper bank bit exists only on large parts; small ones see it low.
    assign tgt      = i_req_bank[BANK_BITS-1:0];
    assign bank_cmd = (i_req_cmd == DDRCB_ACT) || (i_req_cmd == DDRCB_RD) ||
                      (i_req_cmd == DDRCB_WR) || (i_req_cmd == DDRCB_PRE);

    // Legality of a request against the addressed bank or all banks.
    always_comb begin
        legal = 1'b0;
        if (s_ff.st == MN_PD) begin
            legal = (i_req_cmd == DDRCB_PDX) || (i_req_cmd == DDRCB_NOP);
        end else if (s_ff.st == MN_SR) begin
            legal = (i_req_cmd == DDRCB_SRX) || (i_req_cmd == DDRCB_NOP);
        end else begin
            case (i_req_cmd)
                DDRCB_NOP:  legal = 1'b1;
                DDRCB_ACT:  legal = (bank_st[tgt] == BK_IDLE);
                DDRCB_RD, DDRCB_WR, DDRCB_PRE: begin
                    legal = (bank_st[tgt] == BK_ACTIVE) || (bank_st[tgt] == BK_READ) ||
                            (bank_st[tgt] == BK_WRITE);
                end
                DDRCB_PREA: legal = 1'b1;
                DDRCB_REF, DDRCB_MRS, DDRCB_SRE: legal = &bank_idle;
                DDRCB_PDE:  legal = 1'b1;
                default:    legal = 1'b0;
            endcase
        end
    end

    // Stall on transitional banks and running bursts rather than reject.
    always_comb begin
        o_req_ready = 1'b0;
        if (s_ff.st == MN_PD || s_ff.st == MN_SR) begin
            o_req_ready = 1'b1;
        end else if (s_ff.st == MN_RUN && s_ff.bst_cnt == '0) begin
            o_req_ready = bank_cmd ? !bank_busy[tgt] : (i_req_cmd == DDRCB_NOP || !(|bank_busy));
        end
    end

    assign issue   = i_req_valid && o_req_ready && legal;
    assign iss_cmd = i_req_cmd;
    assign iss_ba  = (BANK_BITS < 3) ? {1'b0, i_req_bank[1:0]} : i_req_bank;
    assign iss_ap  = i_req_ap;

    // Main sequencer: builds next pin levels, one command per edge.
    always_comb begin
        nxt_s      = s_ff;
        nxt_s.err  = 1'b0;
        nxt_s.pins = s_ff.cke ? PIN_NOP : PIN_DSEL;
        nxt_s.odt  = i_odt_req && (s_ff.st != MN_SR);
        if (s_ff.bst_cnt != '0) begin
            nxt_s.bst_cnt = s_ff.bst_cnt - 1'b1;
        end
        if (s_ff.wait_cnt != '0) begin
            nxt_s.wait_cnt = s_ff.wait_cnt - 1'b1;
        end
        case (s_ff.st)
            MN_WAIT, MN_EXIT: begin
                if (s_ff.wait_cnt == '0) begin
                    nxt_s.st = MN_RUN;
                end
            end
            MN_PD: begin
                nxt_s.pins   = PIN_DSEL;
                nxt_s.pd_cnt = s_ff.pd_cnt + 1'b1;
                // Forced exit keeps power-down within one refresh interval.
                if ((issue && iss_cmd == DDRCB_PDX) || s_ff.pd_cnt >= CNT_W'(PD_MAX - 1)) begin
                    nxt_s.cke      = 1'b1;
                    nxt_s.st       = MN_EXIT;
                    nxt_s.wait_cnt = CNT_W'(T_XP_CYC - 1);
                end
            end
            MN_SR: begin
                nxt_s.pins = PIN_DSEL;
                nxt_s.odt  = 1'b0;
                if (issue && iss_cmd == DDRCB_SRX) begin
                    nxt_s.cke      = 1'b1;
                    nxt_s.st       = MN_EXIT;
                    nxt_s.wait_cnt = CNT_W'(XSNR_CYC - 1);
                end
            end
            default: begin
                if (issue) begin
                    nxt_s.ba   = iss_ba;
                    nxt_s.addr = i_req_addr;
                    case (iss_cmd)
                        DDRCB_ACT: nxt_s.pins = PIN_ACT;
                        DDRCB_RD, DDRCB_WR: begin
                            nxt_s.pins          = (iss_cmd == DDRCB_RD) ? PIN_RD : PIN_WR;
                            nxt_s.addr          = '0;
                            nxt_s.addr[COL_BITS-1:0] = i_req_addr[COL_BITS-1:0];
                            nxt_s.addr[A_AP_BIT] = iss_ap;
                            nxt_s.bst_cnt       = 2'(BURST_CYC - 1);
                        end
                        DDRCB_PRE, DDRCB_PREA: begin
                            nxt_s.pins           = PIN_PRE;
                            nxt_s.addr[A_AP_BIT] = (iss_cmd == DDRCB_PREA);
                            if (iss_cmd == DDRCB_PREA) begin
                                nxt_s.st       = MN_WAIT;
                                nxt_s.wait_cnt = CNT_W'(C_RP - 1);
                            end
                        end
                        DDRCB_REF: begin
                            nxt_s.pins     = PIN_REF;
                            nxt_s.st       = MN_WAIT;
                            nxt_s.wait_cnt = CNT_W'(C_RFC - 1);
                        end
                        DDRCB_MRS: begin
                            nxt_s.pins     = PIN_MRS;
                            nxt_s.st       = MN_WAIT;
                            nxt_s.wait_cnt = CNT_W'(T_MRD_CYC - 1);
                        end
                        DDRCB_SRE: begin
                            nxt_s.pins = PIN_REF;
                            nxt_s.cke  = 1'b0;
                            nxt_s.odt  = 1'b0;
                            nxt_s.st   = MN_SR;
                        end
                        DDRCB_PDE: begin
                            // Deselect on the entry edge; the MN_PD branch keeps the pins deselected for the whole stay.
                            nxt_s.pins   = PIN_DSEL;
                            nxt_s.cke    = 1'b0;
                            nxt_s.pd_cnt = '0;
                            nxt_s.st     = MN_PD;
                        end
                        default: begin
                        end
                    endcase
                end
            end
        endcase
        // An illegal request is dropped and only flagged; banks stay as they were.
        if (i_req_valid && o_req_ready && !legal) begin
            nxt_s.err = 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            s_ff <= '{st: MN_RUN, wait_cnt: '0, pd_cnt: '0, bst_cnt: '0, cke: 1'b1,
                      pins: PIN_DSEL, ba: '0, addr: '0, odt: 1'b0, err: 1'b0};
        end else begin
            s_ff <= nxt_s;
        end
    end

    // One tracker per bank, updated in step with the registered pins.
    for (genvar b = 0; b < NBANK; b++) begin : g_bank
        assign bank_hit[b]  = issue && s_ff.st == MN_RUN &&
                              ((bank_cmd && tgt == BANK_BITS'(b)) || iss_cmd == DDRCB_PREA);
        assign bank_idle[b] = (bank_st[b] == BK_IDLE);
        ddrcb_bank u_bank (
            .i_ref_clk (i_ref_clk),
            .i_rst     (i_rst),
            .i_hit     (bank_hit[b]),
            .i_cmd     (iss_cmd),
            .i_ap      (iss_ap),
            .o_state   (bank_st[b]),
            .o_busy    (bank_busy[b])
        );
    end

    assign o_cke     = s_ff.cke;
    assign {o_cs_n, o_ras_n, o_cas_n, o_we_n} = s_ff.pins;
    assign o_ba      = s_ff.ba;
    assign o_addr    = s_ff.addr;
    assign o_odt     = s_ff.odt;
    assign o_req_err = s_ff.err;

    logic pins_idle;
    logic col_out;
    logic [NBANK-1:0] idle_q;
    assign pins_idle = o_cs_n || (s_ff.pins == PIN_NOP);
    assign col_out   = !o_cs_n && o_ras_n && !o_cas_n;
    always_ff @(posedge i_ref_clk) begin
        idle_q <= bank_idle;
    end

    chk_odt_self_ref: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_ff.st == MN_SR |-> !o_odt) else $error("termination on in self refresh");
    chk_pd_cke_low: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_ff.st == MN_PD |-> !o_cke && o_cs_n) else $error("power-down pins wrong");
    chk_cke_rise_desel: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        $rose(o_cke) |-> o_cs_n) else $error("CKE rose without deselect");
    chk_recov_nop: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_ff.st == MN_WAIT |=> pins_idle) else $error("command during recovery");
    chk_burst_whole: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        col_out |=> !col_out) else $error("burst interrupted");
    chk_pd_bounded: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_ff.st == MN_PD |-> s_ff.pd_cnt < CNT_W'(PD_MAX)) else $error("power-down too long");
    chk_act_idle_bank: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_ff.pins == PIN_ACT && $past(s_ff.st) == MN_RUN |-> idle_q[o_ba[BANK_BITS-1:0]])
        else $error("activate to non-idle bank");
    chk_err_no_cmd: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_req_err |-> pins_idle) else $error("illegal request reached pins");
    chk_exit_delay: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        s_ff.st == MN_EXIT |-> pins_idle ##1 pins_idle) else $error("command before exit delay");
    chk_ref_all_idle: assert property (@(posedge i_ref_clk) disable iff (i_rst)
        o_cke && s_ff.pins == PIN_REF |-> &idle_q) else $error("refresh with open bank");
endmodule

// >>> verif/ddrcb_dev_model.sv
// Behavioural DDR2 device that watches the pins and flags commands its banks cannot take.
module ddrcb_dev_model
    import ddrcb_pkg::*;
(
    input  wire logic        i_ref_clk,
    input  wire logic        i_cke,
    input  wire logic [3:0]  i_pins,
    input  wire logic [2:0]  i_ba,
    input  wire logic [13:0] i_addr,
    input  wire logic        i_odt,
    output logic             o_bad
);
    timeunit 1ns;
    timeprecision 1ps;
    logic       prev_cke = 1'b1;
    logic       in_sr    = 1'b0;
    logic [3:0] open_bk  = 4'h0;
    int         bk;
    int         cyc      = 0;
    int         last_col = -8;
    // Edges with CKE high throughout are decoded; bank commands are judged against the addressed bank, refresh and mode load against all banks.
    always @(posedge i_ref_clk) begin
        o_bad <= 1'b0;
        cyc = cyc + 1;
        bk = int'(i_ba[1:0]); // Two bank bits decode on this part.
        if (in_sr && i_odt) o_bad <= 1'b1; // Termination must stay off in self refresh.
        if (prev_cke && !i_cke && i_pins == PIN_REF) begin
            if (open_bk != 4'h0) o_bad <= 1'b1;
            in_sr = 1'b1;
        end else if (!prev_cke && i_cke) begin
            in_sr = 1'b0; // Leaving a low-power mode needs no decode.
        end else if (prev_cke && i_cke) begin
            // Deselect and NOP fall to the default and disturb nothing.
            case (i_pins)
                PIN_ACT: if (open_bk[bk]) o_bad <= 1'b1; else open_bk[bk] = 1'b1;
                PIN_RD, PIN_WR: begin
                    // A burst of four may not be cut by the next column command.
                    if (!open_bk[bk] || cyc - last_col < BURST_CYC) o_bad <= 1'b1;
                    else if (i_addr[A_AP_BIT]) open_bk[bk] = 1'b0;
                    last_col = cyc;
                end
                PIN_PRE: if (i_addr[A_AP_BIT]) open_bk = 4'h0; else if (!open_bk[bk]) o_bad <= 1'b1;
                         else open_bk[bk] = 1'b0;
                PIN_REF, PIN_MRS: if (open_bk != 4'h0) o_bad <= 1'b1;
                default: ;
            endcase
        end
        prev_cke = i_cke;
    end
endmodule

// >>> verif/ddr2_command_bank_state_decode_bench.sv
// Self-checking bench: random and directed requests compared with a bank-state model.
module ddr2_command_bank_state_decode_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ddrcb_pkg::*;
    localparam int PD_LIM = 20;
    logic        i_ref_clk   = 1'b0;
    logic        i_rst       = 1'b1;
    logic        i_req_valid = 1'b0;
    ddrcb_cmd_t  i_req_cmd   = DDRCB_NOP;
    logic [2:0]  i_req_bank  = 3'h0;
    logic [13:0] i_req_addr  = 14'h0;
    logic        i_req_ap    = 1'b0;
    logic        i_odt_req   = 1'b0;
    logic        o_req_ready, o_req_err, o_cke, o_cs_n, o_ras_n, o_cas_n, o_we_n, o_odt, bad;
    logic [2:0]  o_ba;
    logic [13:0] o_addr;
    logic [31:0] r;
    int          fails = 0;
    int          n_checks = 0;
    int          seed = 32'h7f84;
    int          cycles = 0;
    int          n;
    int          open_bk[4] = '{0, 0, 0, 0};
    bit          mon = 1'b0;
    ddrcb_cmd_t  pick[5] = '{DDRCB_NOP, DDRCB_ACT, DDRCB_RD, DDRCB_WR, DDRCB_PRE};

    // Free-running reference clock.
    always #10 i_ref_clk = ~i_ref_clk;

    ddrcb_host #(.PD_MAX(PD_LIM), .XSNR_CYC(3)) u_ddrcb_host (
        .i_ref_clk, .i_rst, .i_req_valid, .i_req_cmd, .i_req_bank, .i_req_addr, .i_req_ap, .i_odt_req,
        .o_req_ready, .o_req_err, .o_cke, .o_cs_n, .o_ras_n, .o_cas_n, .o_we_n, .o_ba, .o_addr, .o_odt);
    ddrcb_dev_model u_ddrcb_dev_model (.i_ref_clk, .i_cke(o_cke), .i_pins({o_cs_n, o_ras_n, o_cas_n, o_we_n}),
        .i_ba(o_ba), .i_addr(o_addr), .i_odt(o_odt), .o_bad(bad));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic print_verdict();
        if (fails == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // A hang is cut short here; the ceiling is dozens of times the expected run.
    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles > 20000) begin
            fails++;
            print_verdict();
        end
    end

    // The device model must never see a command its bank cannot take.
    always @(negedge i_ref_clk) begin
        if (mon) chk(bad, 1'b0);
    end

    // Presents one request, holds it until taken, then compares the issued pins with the model.
    task automatic send(input ddrcb_cmd_t cmd, input int b, input logic [13:0] a, input logic ap);
        logic [3:0]  pat;
        logic [3:0]  msk;
        logic [13:0] ea;
        logic        ok;
        logic        ecke;
        logic        banked;
        int          k;
        pat = PIN_NOP;
        msk = 4'hf;
        ea = a;
        ok = 1'b1;
        ecke = 1'b1;
        banked = 1'b1;
        case (cmd)
            DDRCB_ACT: begin ok = !open_bk[b]; pat = PIN_ACT; end
            DDRCB_RD, DDRCB_WR: begin
                ok = open_bk[b];
                pat = (cmd == DDRCB_RD) ? PIN_RD : PIN_WR;
                ea = {3'h0, ap, a[9:0]};
            end
            DDRCB_PRE: begin ok = open_bk[b]; pat = PIN_PRE; ea = {a[13:11], 1'b0, a[9:0]}; end
            DDRCB_PREA: begin pat = PIN_PRE; ea = 14'h0400; banked = 1'b0; end
            DDRCB_REF, DDRCB_SRE: begin
                ok = (open_bk.sum() == 0);
                pat = PIN_REF;
                ecke = (cmd == DDRCB_REF);
                banked = 1'b0;
            end
            DDRCB_MRS: begin ok = (open_bk.sum() == 0); pat = PIN_MRS; end
            DDRCB_PDE, DDRCB_SRX: begin pat = PIN_DSEL; msk = 4'h8; ecke = (cmd == DDRCB_SRX); banked = 1'b0; end
            default: begin msk = (cmd == DDRCB_PDX) ? 4'h0 : 4'hf; banked = 1'b0; end
        endcase
        @(negedge i_ref_clk);
        i_req_valid = 1'b1;
        i_req_cmd = cmd;
        i_req_bank = 3'(b);
        i_req_addr = a;
        i_req_ap = ap;
        #1;
        for (k = 0; k < 60 && o_req_ready !== 1'b1; k++) begin
            @(negedge i_ref_clk);
            #1;
        end
        chk(k < 60, 1'b1);
        @(negedge i_ref_clk);
        i_req_valid = 1'b0;
        chk(o_req_err, !ok);
        chk(o_cke, ok ? ecke : 1'b1);
        chk({o_cs_n, o_ras_n, o_cas_n, o_we_n} & msk, (ok ? pat : PIN_NOP) & msk);
        if (ok && banked) chk({o_ba, o_addr}, {3'(b), ea});
        // Outside self refresh the termination simply follows its request.
        if (cmd inside {DDRCB_NOP, DDRCB_ACT, DDRCB_RD, DDRCB_WR, DDRCB_PRE}) chk(o_odt, i_odt_req);
        if (ok && cmd == DDRCB_ACT) open_bk[b] = 1;
        if (ok && (cmd == DDRCB_PRE || ((cmd == DDRCB_RD || cmd == DDRCB_WR) && ap))) open_bk[b] = 0;
        if (cmd == DDRCB_PREA) open_bk = '{0, 0, 0, 0};
    endtask

    // Main sequence: directed cases first, then random traffic, then the low-power modes.
    initial begin
        repeat (10) @(posedge i_ref_clk);
        @(negedge i_ref_clk);
        i_rst = 1'b0;
        mon = 1'b1;
        send(DDRCB_MRS, 2, 14'h0123, 1'b0);
        send(DDRCB_REF, 0, 14'h0, 1'b0);
        for (int i = 0; i < 4; i++) send(DDRCB_ACT, i, 14'(i * 14'h0551), 1'b0);
        send(DDRCB_REF, 1, 14'h0, 1'b0);
        send(DDRCB_ACT, 3, 14'h0, 1'b0);
        send(DDRCB_PREA, 0, 14'h0, 1'b0);
        send(DDRCB_RD, 2, 14'h0004, 1'b0);
        for (int i = 0; i < 120; i++) begin
            r = $random(seed);
            i_odt_req = r[31];
            send(pick[r[6:4] % 5], int'(r[1:0]), r[29:16], r[8]);
        end
        for (int i = 0; i < 4; i++) if (open_bk[i] != 0) send(DDRCB_PRE, i, 14'h0, 1'b0);
        i_odt_req = 1'b1;
        send(DDRCB_SRE, 0, 14'h0, 1'b0);
        repeat (3) @(negedge i_ref_clk);
        chk(o_odt, 1'b0);
        send(DDRCB_SRX, 0, 14'h0, 1'b0);
        for (n = 0; n < 20 && o_req_ready !== 1'b1; n++) @(negedge i_ref_clk);
        chk(n, 3);
        send(DDRCB_PDE, 0, 14'h0, 1'b0);
        send(DDRCB_PDX, 0, 14'h0, 1'b0);
        send(DDRCB_PDE, 0, 14'h0, 1'b0);
        for (n = 0; n < 40 && o_cke !== 1'b1; n++) @(negedge i_ref_clk);
        chk((n >= PD_LIM - 3) && (n <= PD_LIM), 1'b1);
        send(DDRCB_ACT, 1, 14'h0222, 1'b0);
        send(DDRCB_WR, 1, 14'h3fff, 1'b1);
        repeat (4) @(negedge i_ref_clk);
        print_verdict();
    end
endmodule
